/* logic/acpoc_pkg.sv */
// Shared constants and carrier types for the converter control block.
// Assumes a single conversion clock domain; no bus, all control bits are ports.
package acpoc_pkg;
  localparam int RESULT_WIDTH = 12;
  localparam int REQUEST_MIN_CYCLES = 3;
  localparam int READY_DROP_CYCLES = 3;
  localparam int SEQUENCE_CYCLES = 4000;
  // Latency figure is 10.25 cycles; whole cycles carried by the pipeline.
  localparam int RESULT_LATENCY_CYCLES = 10;
  localparam int COUNT_WIDTH = 13;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 13'h0000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 13'h0001;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;

  typedef struct packed {
    logic valid;
    logic [RESULT_WIDTH-1:0] data;
  } acpoc_word_type;

  typedef struct packed {
    logic [RESULT_WIDTH-1:0] out;
    logic [RESULT_WIDTH-1:0] oe;
  } acpoc_bus_type;

  typedef enum logic [2:0] {
    ACPOC_RUN,
    ACPOC_CAL_WAIT,
    ACPOC_CAL,
    ACPOC_PD_WAIT,
    ACPOC_PD,
    ACPOC_PD_EXIT
  } acpoc_state_type;
endpackage

/* logic/acpoc_skid.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes the same clock and synchronous active-low reset as its parent.
`timescale 1ns/1ps
module acpoc_skid
  import acpoc_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [2];
  logic [WIDTH-1:0] next_mem [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  logic next_rd_ptr;
  logic next_wr_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    push = in_valid && (count != 2'h2);
    pop = out_valid && out_ready;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
    mem <= next_mem;
  end

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
endmodule

/* logic/acpoc_top.sv */
// Digital control and output stage of a pipelined sampling converter.
// Assumes the conversion clock is core_clk and pins arrive asynchronously.
// Functional notes
// - Ready drops three periods after calibration request; calibration lasts 4000 periods.
// - Power-down request held three periods; ready drops three periods later.
// - Leaving power-down takes 4000 periods before conversion resumes.
// - Result updates each rising edge, appearing 10.25 cycles after sampling.
// - Output enable released floats every result line.
// - Output enable asserted again drives the result lines once more.
// - Output enable is active low: drive while low, float while high.
// - While power-down request is high, stay low power; pipeline results invalid. Code enters power-down only from run.
// - Calibration request is level sensitive, starting after three high cycles.
`timescale 1ns/1ps
module acpoc_top
  import acpoc_pkg::*;
#(
  parameter int SEQUENCE_LEN = SEQUENCE_CYCLES,
  parameter int LATENCY = RESULT_LATENCY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic calibrate_request,
  input wire logic power_down_request,
  input wire logic output_enable_n,
  input wire logic [RESULT_WIDTH-1:0] sample_data,
  output logic ready,
  output logic power_down_active,
  output logic result_valid,
  output logic [RESULT_WIDTH-1:0] conversion_result_out,
  output logic [RESULT_WIDTH-1:0] conversion_result_oe
);
  logic [1:0] cal_sync;
  logic [1:0] pd_sync;
  logic [1:0] oe_sync;
  logic [1:0] next_cal_sync;
  logic [1:0] next_pd_sync;
  logic [1:0] next_oe_sync;
  logic [1:0] cal_high;
  logic [1:0] pd_high;
  logic [1:0] next_cal_high;
  logic [1:0] next_pd_high;
  logic cal_seen;
  logic pd_seen;
  acpoc_state_type state;
  acpoc_state_type next_state;
  logic [COUNT_WIDTH-1:0] count;
  logic [COUNT_WIDTH-1:0] next_count;
  logic next_ready;
  logic next_power_down_active;
  acpoc_word_type pipe [LATENCY-1];
  acpoc_word_type next_pipe [LATENCY-1];
  logic buf_in_ready;
  logic buf_out_valid;
  logic [RESULT_WIDTH-1:0] buf_out_data;
  acpoc_bus_type pins;
  acpoc_bus_type next_pins;
  logic next_result_valid;

  function automatic logic [COUNT_WIDTH-1:0] to_count(input int value);
    to_count = value[COUNT_WIDTH-1:0];
  endfunction

  // Request level filter: counts high cycles after the two-stage synchroniser.
  always_comb begin
    next_cal_sync = {cal_sync[0], calibrate_request};
    next_pd_sync = {pd_sync[0], power_down_request};
    next_oe_sync = {oe_sync[0], output_enable_n};
    next_cal_high = cal_sync[1] ? ((cal_high == 2'h3) ? cal_high : cal_high + 2'h1) : 2'h0;
    next_pd_high = pd_sync[1] ? ((pd_high == 2'h3) ? pd_high : pd_high + 2'h1) : 2'h0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cal_sync <= 2'h0;
      pd_sync <= 2'h0;
      oe_sync <= 2'h3;
      cal_high <= 2'h0;
      pd_high <= 2'h0;
    end else begin
      cal_sync <= next_cal_sync;
      pd_sync <= next_pd_sync;
      oe_sync <= next_oe_sync;
      cal_high <= next_cal_high;
      pd_high <= next_pd_high;
    end
  end

  // The third consecutive high sample qualifies a request; shorter pulses are dropped.
  assign cal_seen = cal_sync[1] && (cal_high == 2'(REQUEST_MIN_CYCLES - 1));
  assign pd_seen = pd_sync[1] && (pd_high == 2'(REQUEST_MIN_CYCLES - 1));

  // Sequencer for calibration and power-down.
  always_comb begin
    next_state = state;
    next_count = count;
    next_ready = ready;
    next_power_down_active = power_down_active;
    case (state)
      ACPOC_RUN: begin
        next_ready = 1'b1;
        if (pd_seen) begin
          next_state = ACPOC_PD_WAIT;
          next_count = to_count(READY_DROP_CYCLES - 1);
        end else if (cal_seen) begin
          next_state = ACPOC_CAL_WAIT;
          next_count = to_count(READY_DROP_CYCLES - 1);
        end
      end
      ACPOC_CAL_WAIT: begin
        if (count == COUNT_ZERO) begin
          next_ready = 1'b0;
          next_state = ACPOC_CAL;
          next_count = to_count(SEQUENCE_LEN - 1);
        end else begin
          next_count = count - COUNT_ONE;
        end
      end
      ACPOC_CAL: begin
        if (count == COUNT_ZERO) begin
          next_ready = 1'b1;
          next_state = ACPOC_RUN;
        end else begin
          next_count = count - COUNT_ONE;
        end
      end
      ACPOC_PD_WAIT: begin
        if (count == COUNT_ZERO) begin
          next_ready = 1'b0;
          next_power_down_active = 1'b1;
          next_state = ACPOC_PD;
        end else begin
          next_count = count - COUNT_ONE;
        end
      end
      ACPOC_PD: begin
        if (!pd_sync[1]) begin
          next_state = ACPOC_PD_EXIT;
          next_count = to_count(SEQUENCE_LEN - 1);
        end
      end
      ACPOC_PD_EXIT: begin
        if (pd_sync[1]) begin
          next_state = ACPOC_PD;
        end else if (count == COUNT_ZERO) begin
          next_ready = 1'b1;
          next_power_down_active = 1'b0;
          next_state = ACPOC_RUN;
        end else begin
          next_count = count - COUNT_ONE;
        end
      end
      default: begin
        next_state = ACPOC_RUN;
        next_count = COUNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ACPOC_RUN;
      count <= COUNT_ZERO;
      ready <= 1'b1;
      power_down_active <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      ready <= next_ready;
      power_down_active <= next_power_down_active;
    end
  end

  // Result pipeline: a word is marked invalid when taken during power-down or
  // calibration, so stale data never reaches the buffer as valid.
  // The buffer entry and the pin register are the last two stages, so a word reaches
  // the pins LATENCY edges after it was sampled; the quarter cycle is output delay.
  always_comb begin
    next_pipe[0].valid = ready && !power_down_active;
    next_pipe[0].data = sample_data;
    for (int i = 1; i < LATENCY - 1; i++) begin
      next_pipe[i] = pipe[i-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < LATENCY - 1; i++) begin
        pipe[i] <= '{valid: 1'b0, data: RESULT_RESET};
      end
    end else begin
      pipe <= next_pipe;
    end
  end

  acpoc_skid #(
    .WIDTH(RESULT_WIDTH)
  ) u_buffer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(pipe[LATENCY-2].valid),
    .in_ready(buf_in_ready),
    .in_data(pipe[LATENCY-2].data),
    .out_valid(buf_out_valid),
    .out_ready(1'b1),
    .out_data(buf_out_data)
  );

  // The pin stage always drains, so the buffer never fills and no word is lost;
  // in_ready is kept for a receiver that may later stall.
  always_comb begin
    next_pins.out = buf_out_valid ? buf_out_data : pins.out;
    next_pins.oe = {RESULT_WIDTH{~oe_sync[1]}};
    next_result_valid = buf_out_valid && buf_in_ready;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pins <= '{out: RESULT_RESET, oe: RESULT_RESET};
      result_valid <= 1'b0;
    end else begin
      pins <= next_pins;
      result_valid <= next_result_valid;
    end
  end

  assign conversion_result_out = pins.out;
  assign conversion_result_oe = pins.oe;
endmodule

/* sim/acpoc_checker.sv */
// Concurrent checks on the converter control block's ports.
// Assumes the one conversion clock and synchronous active-low reset.
`timescale 1ns/1ps
module acpoc_checker
  import acpoc_pkg::*;
#(
  parameter int SEQUENCE_LEN = 20,
  parameter int LATENCY = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic calibrate_request,
  input wire logic power_down_request,
  input wire logic output_enable_n,
  input wire logic [RESULT_WIDTH-1:0] sample_data,
  input wire logic ready,
  input wire logic power_down_active,
  input wire logic result_valid,
  input wire logic [RESULT_WIDTH-1:0] conversion_result_out,
  input wire logic [RESULT_WIDTH-1:0] conversion_result_oe
);
  int low_n;
  int exit_n;
  int up;
  // The warm-up count keeps pin history from inside reset out of the enable checks.
  always_ff @(posedge core_clk) begin
    low_n <= (!rst_n || ready) ? 0 : low_n + 1;
    exit_n <= (!rst_n || power_down_request) ? 0 : exit_n + 1;
    up <= !rst_n ? 0 : ((up < 8) ? up + 1 : up);
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  oe_float_a: assert property ((output_enable_n && up == 8) [*5] |->
    conversion_result_oe == 12'h000) else $error("result lines not floated");
  oe_drive_a: assert property ((!output_enable_n && up == 8) [*5] |->
    conversion_result_oe == 12'hFFF) else $error("result lines not driven");
  cal_drop_a: assert property ($rose(calibrate_request) && ready &&
    !power_down_request ##1 calibrate_request [*2] |-> ready [*3] ##[1:4] !ready)
    else $error("ready drop late");
  cal_short_a: assert property (ready && !power_down_request && !calibrate_request
    ##1 calibrate_request [*2] ##1 (!calibrate_request && !power_down_request) [*6] |-> ready)
    else $error("short pulse");
  cal_len_a: assert property ($rose(ready) && !$past(power_down_active) |->
    low_n == SEQUENCE_LEN) else $error("calibration length wrong");
  pd_drop_a: assert property (ready && power_down_request
    ##1 power_down_request [*8] |-> !ready && power_down_active)
    else $error("power-down not entered");
  pd_exit_a: assert property ($rose(ready) && $past(power_down_active) |->
    exit_n >= SEQUENCE_LEN && exit_n <= SEQUENCE_LEN + 8) else $error("exit length wrong");
  hold_out_a: assert property (!result_valid |-> $stable(conversion_result_out))
    else $error("result changed without a word");
  idle_out_a: assert property (low_n > LATENCY + 4 |-> !result_valid)
    else $error("word during power-down");
  cover property ($rose(ready) && $past(power_down_active));
  cover property ($fell(ready) && !power_down_active);
  cover property (result_valid && conversion_result_oe == 12'hFFF);
endmodule
bind acpoc_top acpoc_checker #(.SEQUENCE_LEN(SEQUENCE_LEN), .LATENCY(LATENCY)) i_acpoc_checker (
  .core_clk(core_clk), .rst_n(rst_n), .calibrate_request(calibrate_request),
  .power_down_request(power_down_request), .output_enable_n(output_enable_n),
  .sample_data(sample_data), .ready(ready), .power_down_active(power_down_active),
  .result_valid(result_valid), .conversion_result_out(conversion_result_out),
  .conversion_result_oe(conversion_result_oe));

/* sim/acpoc_host_model.sv */
// Host side: resolves the result pins and counts the words it captures.
// Assumes the result pins have no pull, so an undriven pin floats.
`timescale 1ns/1ps
module acpoc_host_model
  import acpoc_pkg::*;
(
  input wire logic core_clk,
  input wire logic result_valid,
  input wire logic [RESULT_WIDTH-1:0] conversion_result_out,
  input wire logic [RESULT_WIDTH-1:0] conversion_result_oe,
  output wire [RESULT_WIDTH-1:0] pins,
  output int words
);
  for (genvar i = 0; i < RESULT_WIDTH; i++) begin : g_pin
    assign pins[i] = conversion_result_oe[i] ? conversion_result_out[i] : 1'bz;
  end
  always @(posedge core_clk) begin
    if (result_valid === 1'b1) begin
      words <= words + 1;
    end
  end
endmodule

/* sim/acpoc_top_tb.sv */
// Self-checking bench for the converter control block.
// Assumes a shortened sequence length so calibration and exit stay brief.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module acpoc_top_tb;
  import acpoc_pkg::*;
  localparam int SEQ = 20;
  // A result launched LATENCY edges after its sample is read at the edge after that.
  localparam int LAT_EDGES = RESULT_LATENCY_CYCLES + 1;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic calibrate_request = 1'b0;
  logic power_down_request = 1'b0;
  logic output_enable_n = 1'b1;
  logic [RESULT_WIDTH-1:0] sample_data = 12'h000;
  logic ready, power_down_active, result_valid;
  logic [RESULT_WIDTH-1:0] conversion_result_out, conversion_result_oe;
  wire [RESULT_WIDTH-1:0] pins;
  int words, fails, n_tests, cyc, n;
  int hist_c[$];
  logic [RESULT_WIDTH-1:0] hist_d[$];
  // The clock runs far above the host's pin range; only cycle counts matter here.
  always #5 core_clk = ~core_clk;
  acpoc_top #(.SEQUENCE_LEN(SEQ), .LATENCY(RESULT_LATENCY_CYCLES)) i_acpoc_top (
    .core_clk(core_clk),
    .rst_n(rst_n), .calibrate_request(calibrate_request),
    .power_down_request(power_down_request), .output_enable_n(output_enable_n),
    .sample_data(sample_data), .ready(ready), .power_down_active(power_down_active),
    .result_valid(result_valid), .conversion_result_out(conversion_result_out),
    .conversion_result_oe(conversion_result_oe));
  acpoc_host_model i_acpoc_host_model (.core_clk(core_clk), .result_valid(result_valid),
    .conversion_result_out(conversion_result_out),
    .conversion_result_oe(conversion_result_oe), .pins(pins), .words(words));
  task automatic close_out();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cycles(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic wait_ready(input logic v, input int lim, output int k);
    k = 0;
    while (ready !== v && k < lim) begin
      @(posedge core_clk);
      k++;
    end
  endtask
  // Every sample is noted; dropped ones are skipped by age, never by value.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 1000) begin
      fails++;
      close_out();
    end
    if (result_valid === 1'b1) begin
      while (hist_c.size() > 1 && hist_c[0] < cyc - LAT_EDGES) begin
        void'(hist_c.pop_front());
        void'(hist_d.pop_front());
      end
      `CHK(cyc - hist_c[0], LAT_EDGES)
      `CHK(conversion_result_out, hist_d[0])
    end
    if (rst_n) begin
      hist_c.push_back(cyc);
      hist_d.push_back(sample_data);
    end
    sample_data <= 12'($urandom);
  end
  initial begin
    void'($urandom(32'h16a55691));
    cycles(8);
    rst_n <= 1'b1;
    cycles(1);
    `CHK({ready, power_down_active, result_valid}, 3'b100)
    output_enable_n <= 1'b0;
    cycles(40);
    `CHK(pins === conversion_result_out && words > 20, 1'b1)
    calibrate_request <= 1'b1;
    cycles(2);
    calibrate_request <= 1'b0;
    cycles(10);
    `CHK(ready, 1'b1)
    calibrate_request <= 1'b1;
    cycles(3);
    calibrate_request <= 1'b0;
    wait_ready(1'b0, 10, n);
    `CHK(n <= 8, 1'b1)
    wait_ready(1'b1, 2 * SEQ, n);
    `CHK(n, SEQ)
    cycles(30);
    power_down_request <= 1'b1;
    cycles(30);
    `CHK({ready, power_down_active}, 2'b01)
    power_down_request <= 1'b0;
    wait_ready(1'b1, 2 * SEQ + 10, n);
    `CHK(n >= SEQ && n <= SEQ + 6, 1'b1)
    output_enable_n <= 1'b1;
    cycles(6);
    `CHK(pins, 12'hzzz)
    output_enable_n <= 1'b0;
    cycles(6);
    `CHK(conversion_result_oe, 12'hFFF)
    // A reset in the middle of a calibration must bring the block straight back to run.
    calibrate_request <= 1'b1;
    cycles(3);
    calibrate_request <= 1'b0;
    wait_ready(1'b0, 10, n);
    `CHK(ready, 1'b0)
    rst_n <= 1'b0;
    cycles(3);
    rst_n <= 1'b1;
    cycles(1);
    `CHK({ready, power_down_active, result_valid}, 3'b100)
    cycles(30);
    close_out();
  end
endmodule
